// ---- hw/intc_prio_pkg.sv ----
// Purpose: constants and types for the interrupt priority register block
// Assumes: 16-bit registers on a plain strobe port
// Notes: offsets are word indices on the register port
package intc_prio_pkg;

	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned PRIO_W = 3;
	localparam int unsigned VEC_W = 7;
	localparam int unsigned NUM_SRC = 16;

	// register offsets
	localparam logic [3:0] OFS_FLAG_STATUS_0 = 4'h0;
	localparam logic [3:0] OFS_PRIO_CTL_1 = 4'h1;
	localparam logic [3:0] OFS_PRIO_CTL_18 = 4'h2;
	localparam logic [3:0] OFS_PRIO_CTL_20 = 4'h3;
	localparam logic [3:0] OFS_CTL_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h5;

	// implemented flag bits, plus spare slots 14 and 9 that carry
	// the voltage detect and wake-up flags into arbitration
	localparam logic [15:0] FLAG_IMPL_MASK = 16'hfbcd;

	// field positions
	localparam int unsigned POS_TIMER_TWO = 12;
	localparam int unsigned POS_CAPTURE_TWO = 8;
	localparam int unsigned POS_LOW_PRIO = 0;
	localparam int unsigned POS_CPU_REQ = 15;
	localparam int unsigned POS_VECTOR_HOLD_SELECT = 13;
	localparam int unsigned POS_LEVEL = 8;

	// reset values
	localparam logic [2:0] PRIO_RESET = 3'h4;
	localparam logic [15:0] FLAG_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [2:0] PRIO_OFF = 3'h0;

	// source indices in the request vector
	localparam int unsigned SRC_TIMER_TWO = 7;
	localparam int unsigned SRC_CAPTURE_TWO = 6;
	localparam int unsigned SRC_VOLT_DET = 14;
	localparam int unsigned SRC_LOW_WAKE = 9;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// ---- hw/intc_prio_regs.sv ----
// Purpose: sticky flags, source priorities and pending vector report
// Assumes: single clock, sources are synchronous one-cycle or level pulses
// Notes: four prioritised sources arbitrate, the other implemented ones only flag
`timescale 1ns/100ps

// Notes on behaviour
// - priority codes 001..111 are levels 1..7
// - code 000 keeps the source out of arbitration; its flag and irq path still work
// - voltage detect priority bits 2-0, reset 4
// - wake-up priority bits 2-0, reset 4
// - upper bits read zero, writes ignored
module intc_prio_regs
	import intc_prio_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// register port
	input wire reg_req_t req_i,
	output logic [DATA_W-1:0] rdata_o,
	// interrupt sources
	input wire logic [NUM_SRC-1:0] src_req_i,
	// current processor level
	input wire logic [3:0] cpu_level_i,
	// to the processor
	output logic cpu_request_pending_o,
	output logic [VEC_W-1:0] pending_vector_number_o,
	output logic irq_o
);

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [15:0] flags_q;
	logic [15:0] mask_q;
	logic [2:0] timer_two_priority_q;
	logic [2:0] capture_two_priority_q;
	logic [2:0] voltage_detect_priority_q;
	logic [2:0] low_power_wake_priority_q;
	logic vector_hold_select_q;
	logic [3:0] cpu_level_report_q;
	logic [VEC_W-1:0] last_ack_vec_q;
	logic wr_flag;
	logic wr_p1;
	logic wr_p18;
	logic wr_p20;
	logic wr_ctl;
	logic wr_mask;

	assign wr_flag = req_i.wr && (req_i.addr == OFS_FLAG_STATUS_0);
	assign wr_p1 = req_i.wr && (req_i.addr == OFS_PRIO_CTL_1);
	assign wr_p18 = req_i.wr && (req_i.addr == OFS_PRIO_CTL_18);
	assign wr_p20 = req_i.wr && (req_i.addr == OFS_PRIO_CTL_20);
	assign wr_ctl = req_i.wr && (req_i.addr == OFS_CTL_STATUS);
	assign wr_mask = req_i.wr && (req_i.addr == OFS_IRQ_MASK);

	// sticky flags: set wins over a software clear
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			flags_q <= FLAG_RESET;
		else if (wr_flag)
			flags_q <= ((flags_q & req_i.wdata) | src_req_i) & FLAG_IMPL_MASK;
		else
			flags_q <= (flags_q | src_req_i) & FLAG_IMPL_MASK;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			mask_q <= MASK_RESET;
		else if (wr_mask)
			mask_q <= req_i.wdata & FLAG_IMPL_MASK;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			timer_two_priority_q <= PRIO_RESET;
			capture_two_priority_q <= PRIO_RESET;
		end
		else if (wr_p1)
		begin
			timer_two_priority_q <= req_i.wdata[POS_TIMER_TWO +: PRIO_W];
			capture_two_priority_q <= req_i.wdata[POS_CAPTURE_TWO +: PRIO_W];
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			voltage_detect_priority_q <= PRIO_RESET;
		else if (wr_p18)
			voltage_detect_priority_q <= req_i.wdata[POS_LOW_PRIO +: PRIO_W];
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			low_power_wake_priority_q <= PRIO_RESET;
		else if (wr_p20)
			low_power_wake_priority_q <= req_i.wdata[POS_LOW_PRIO +: PRIO_W];
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			vector_hold_select_q <= 1'b0;
		else if (wr_ctl)
			vector_hold_select_q <= req_i.wdata[POS_VECTOR_HOLD_SELECT];
	end

	// ****************************************************************
	// arbitration
	// ****************************************************************
	logic [2:0] best_lvl;
	logic [VEC_W-1:0] best_vec;

	function automatic logic [VEC_W-1:0] vec_of(input int unsigned src);
		vec_of = VEC_W'(src + 8);
	endfunction

	always_comb
	begin
		best_lvl = PRIO_OFF;
		best_vec = '0;
		// lower vector wins ties; code 000 never beats PRIO_OFF
		if (flags_q[SRC_VOLT_DET] && voltage_detect_priority_q > best_lvl)
		begin
			best_lvl = voltage_detect_priority_q;
			best_vec = vec_of(SRC_VOLT_DET);
		end
		if (flags_q[SRC_LOW_WAKE] && low_power_wake_priority_q >= best_lvl
			&& low_power_wake_priority_q != PRIO_OFF)
		begin
			best_lvl = low_power_wake_priority_q;
			best_vec = vec_of(SRC_LOW_WAKE);
		end
		if (flags_q[SRC_TIMER_TWO] && timer_two_priority_q >= best_lvl
			&& timer_two_priority_q != PRIO_OFF)
		begin
			best_lvl = timer_two_priority_q;
			best_vec = vec_of(SRC_TIMER_TWO);
		end
		if (flags_q[SRC_CAPTURE_TWO] && capture_two_priority_q >= best_lvl
			&& capture_two_priority_q != PRIO_OFF)
		begin
			best_lvl = capture_two_priority_q;
			best_vec = vec_of(SRC_CAPTURE_TWO);
		end
	end

	logic req_now;
	assign req_now = (best_lvl != PRIO_OFF) && ({1'b0, best_lvl} > cpu_level_i);

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cpu_request_pending_o <= 1'b0;
			pending_vector_number_o <= '0;
			cpu_level_report_q <= 4'h0;
			last_ack_vec_q <= '0;
		end
		else
		begin
			cpu_request_pending_o <= req_now;
			cpu_level_report_q <= cpu_level_i;
			if (req_now)
				last_ack_vec_q <= best_vec;
			pending_vector_number_o <= vector_hold_select_q ? last_ack_vec_q : best_vec;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(flags_q & mask_q);
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_o <= 16'h0000;
		else if (req_i.rd)
		begin
			rdata_o <= 16'h0000;
			if (req_i.addr == OFS_FLAG_STATUS_0)
				rdata_o <= flags_q;
			else if (req_i.addr == OFS_PRIO_CTL_1)
			begin
				rdata_o[POS_TIMER_TWO +: PRIO_W] <= timer_two_priority_q;
				rdata_o[POS_CAPTURE_TWO +: PRIO_W] <= capture_two_priority_q;
			end
			else if (req_i.addr == OFS_PRIO_CTL_18)
				rdata_o[POS_LOW_PRIO +: PRIO_W] <= voltage_detect_priority_q;
			else if (req_i.addr == OFS_PRIO_CTL_20)
				rdata_o[POS_LOW_PRIO +: PRIO_W] <= low_power_wake_priority_q;
			else if (req_i.addr == OFS_CTL_STATUS)
			begin
				rdata_o[POS_CPU_REQ] <= cpu_request_pending_o;
				rdata_o[POS_VECTOR_HOLD_SELECT] <= vector_hold_select_q;
				rdata_o[POS_LEVEL +: 4] <= cpu_level_report_q;
				rdata_o[VEC_W-1:0] <= pending_vector_number_o;
			end
			else if (req_i.addr == OFS_IRQ_MASK)
				rdata_o <= mask_q;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_flag_sticky;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		flags_q[SRC_TIMER_TWO] && !wr_flag |=> flags_q[SRC_TIMER_TWO];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

	property p_flag_set;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		src_req_i[SRC_VOLT_DET] |=> flags_q[SRC_VOLT_DET];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	property p_disabled_silent;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		flags_q == (16'h0001 << SRC_VOLT_DET) && voltage_detect_priority_q == PRIO_OFF
		|=> !cpu_request_pending_o;
	endproperty
	a_disabled_silent: assert property (p_disabled_silent) else $error("disabled source");

	property p_level_seven;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		flags_q[SRC_LOW_WAKE] && low_power_wake_priority_q == 3'h7 && cpu_level_i < 4'h7
		|=> cpu_request_pending_o;
	endproperty
	a_level_seven: assert property (p_level_seven) else $error("level 7 lost");

	property p_p18_read;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		req_i.rd && req_i.addr == OFS_PRIO_CTL_18
		|=> rdata_o[15:3] == 13'h0 && rdata_o[2:0] == $past(voltage_detect_priority_q);
	endproperty
	a_p18_read: assert property (p_p18_read) else $error("bad read");

	property p_p20_read;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		req_i.rd && req_i.addr == OFS_PRIO_CTL_20 |=> rdata_o[15:3] == 13'h0;
	endproperty
	a_p20_read: assert property (p_p20_read) else $error("upper bits set");

	property p_wake_write;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_p20 |=> low_power_wake_priority_q == $past(req_i.wdata[2:0]);
	endproperty
	a_wake_write: assert property (p_wake_write) else $error("wake write");

	property p_irq;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		|(flags_q & mask_q) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");

	property p_irq_off;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		!(|(flags_q & mask_q)) |=> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq without flag");

	property p_wake_set;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		src_req_i[SRC_LOW_WAKE] |=> flags_q[SRC_LOW_WAKE];
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

	property p_volt_sticky;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		flags_q[SRC_VOLT_DET] && !wr_flag |=> flags_q[SRC_VOLT_DET];
	endproperty
	a_volt_sticky: assert property (p_volt_sticky) else $error("voltage flag lost");

	// software clear of a flag with no new request behind it
	sequence s_timer_cleared;
		wr_flag && !req_i.wdata[SRC_TIMER_TWO] && !src_req_i[SRC_TIMER_TWO];
	endsequence

	property p_flag_clear;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		s_timer_cleared |=> !flags_q[SRC_TIMER_TWO];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	// ****************************************************************
	// checks: arbitration path, register writes and control readback
	// ****************************************************************
	// wake-up raised at top level, core running below it
	sequence s_wake_raise;
		src_req_i[SRC_LOW_WAKE] && low_power_wake_priority_q == 3'h7 && !wr_p20;
	endsequence

	sequence s_level_below;
		cpu_level_i < 4'h7;
	endsequence

	property p_wake_path;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		s_wake_raise ##1 s_level_below |=> cpu_request_pending_o;
	endproperty
	a_wake_path: assert property (p_wake_path) else $error("wake request lost");

	property p_p1_write;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_p1 |=> timer_two_priority_q == $past(req_i.wdata[14:12])
			&& capture_two_priority_q == $past(req_i.wdata[10:8]);
	endproperty
	a_p1_write: assert property (p_p1_write) else $error("priority write");

	property p_volt_write;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_p18 |=> voltage_detect_priority_q == $past(req_i.wdata[2:0]);
	endproperty
	a_volt_write: assert property (p_volt_write) else $error("voltage write");

	property p_hold_write;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_ctl |=> vector_hold_select_q == $past(req_i.wdata[13]);
	endproperty
	a_hold_write: assert property (p_hold_write) else $error("hold write");

	// hold shows the last acknowledged vector, not the live winner
	property p_hold_vector;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		vector_hold_select_q |=> pending_vector_number_o == $past(last_ack_vec_q);
	endproperty
	a_hold_vector: assert property (p_hold_vector) else $error("held vector");

	property p_ctl_reserved;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		req_i.rd && req_i.addr == OFS_CTL_STATUS
		|=> !rdata_o[14] && !rdata_o[12] && !rdata_o[7];
	endproperty
	a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved bit set");

endmodule

// ---- testbench/cpu_core_model.sv ----
// Purpose: processor side that takes prioritised requests
// Assumes: level changes are registered, one clock
// Notes: the bench chooses the running level
`timescale 1ns/100ps
module cpu_core_model
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// level asked for by the bench
	input wire logic [3:0] set_level_i,
	// request seen from the block
	input wire logic cpu_request_pending_i,
	output logic [3:0] cpu_level_o,
	output logic req_seen_o
);
	// sticky: any request seen since reset
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			req_seen_o <= 1'b0;
		else if (cpu_request_pending_i)
			req_seen_o <= 1'b1;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cpu_level_o <= 4'h0;
		else
			cpu_level_o <= set_level_i;
	end
endmodule

// ---- testbench/interrupt_priority_registers_tb.sv ----
// Purpose: self-checking bench for the priority register block
// Assumes: read data valid the cycle after the read strobe
// Notes: tests run in sequence, the timeout ends a hang
`timescale 1ns/100ps
module interrupt_priority_registers_tb
	import intc_prio_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	reg_req_t req = '0;
	logic [15:0] src = 16'h0;
	logic [3:0] lvl_set = 4'h0;
	logic [3:0] cpu_lvl;
	logic [15:0] rdata;
	logic pend;
	logic [6:0] vec;
	logic irq;
	logic seen;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;

	intc_prio_regs i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req),
		.rdata_o(rdata), .src_req_i(src), .cpu_level_i(cpu_lvl),
		.cpu_request_pending_o(pend), .pending_vector_number_o(vec), .irq_o(irq));
	cpu_core_model i_cpu (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.set_level_i(lvl_set), .cpu_request_pending_i(pend), .cpu_level_o(cpu_lvl),
		.req_seen_o(seen));

	initial
	begin
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_i) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys_i) req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys_i) req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys_i) req.rd <= 1'b0;
		@(negedge clk_sys_i) d = rdata;
	endtask

	task automatic pulse(input logic [15:0] s);
		@(posedge clk_sys_i) src <= s;
		@(posedge clk_sys_i) src <= 16'h0;
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		logic [15:0] d;
		rd(OFS_PRIO_CTL_1, d);
		chk(d, 16'h4400);
		rd(OFS_PRIO_CTL_18, d);
		chk(d, 16'h0004);
		rd(OFS_PRIO_CTL_20, d);
		chk(d, 16'h0004);
		rd(OFS_FLAG_STATUS_0, d);
		chk(d, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_upper;
		logic [15:0] d;
		wr(OFS_PRIO_CTL_18, 16'hffff);
		wr(OFS_PRIO_CTL_20, 16'hfffa);
		rd(OFS_PRIO_CTL_18, d);
		chk(d, 16'h0007);
		rd(OFS_PRIO_CTL_20, d);
		chk(d, 16'h0002);
		$display("test upper bits done");
	endtask

	task automatic t_flags;
		logic [15:0] d;
		wr(OFS_IRQ_MASK, 16'h0001);
		pulse(16'h0001);
		rd(OFS_FLAG_STATUS_0, d);
		chk(d, 16'h0001);
		chk({15'h0, irq}, 16'h0001);
		wr(OFS_FLAG_STATUS_0, 16'h0000);
		@(negedge clk_sys_i);
		rd(OFS_FLAG_STATUS_0, d);
		chk(d, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		$display("test flags done");
	endtask

	task automatic t_levels;
		wr(OFS_PRIO_CTL_18, 16'h0000);
		pulse(16'h4000);
		chk({15'h0, pend}, 16'h0000);
		wr(OFS_PRIO_CTL_18, 16'h0001);
		repeat (3) @(negedge clk_sys_i);
		chk({15'h0, pend}, 16'h0001);
		chk({9'h0, vec}, 16'h0016);
		@(posedge clk_sys_i) lvl_set <= 4'h1;
		repeat (4) @(negedge clk_sys_i);
		chk({15'h0, pend}, 16'h0000);
		wr(OFS_PRIO_CTL_20, 16'h0007);
		pulse(16'h0200);
		chk({15'h0, pend}, 16'h0001);
		chk({9'h0, vec}, 16'h0011);
		$display("test levels done");
	endtask

	task automatic t_ctl;
		logic [15:0] d;
		rd(OFS_CTL_STATUS, d);
		chk(d, 16'h8111);
		chk({15'h0, seen}, 16'h0001);
		wr(OFS_CTL_STATUS, 16'h2000);
		wr(OFS_FLAG_STATUS_0, 16'hfdff);
		rd(OFS_CTL_STATUS, d);
		chk(d, 16'h2111);
		chk({9'h0, vec}, 16'h0011);
		wr(OFS_CTL_STATUS, 16'h0000);
		wr(OFS_PRIO_CTL_1, 16'h3500);
		pulse(16'h00c0);
		chk({15'h0, pend}, 16'h0001);
		chk({9'h0, vec}, 16'h000e);
		chk({15'h0, irq}, 16'h0000);
		wr(OFS_IRQ_MASK, 16'h4000);
		rd(OFS_IRQ_MASK, d);
		chk(d, 16'h4000);
		chk({15'h0, irq}, 16'h0001);
		wr(OFS_FLAG_STATUS_0, 16'h0000);
		rd(OFS_FLAG_STATUS_0, d);
		chk(d, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		$display("test control status done");
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			$display("[FAIL] %0t run timed out", $time);
			give_verdict();
		end
	end

	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		t_reset();
		t_upper();
		t_flags();
		t_levels();
		t_ctl();
		give_verdict();
	end
endmodule
